// ===== pkg/cawd_regs.svh
// Register offsets, field positions, reset values and timing counts of the counter array block.
// Assumes a 32-bit APB slave decoding byte addresses on an 8-bit offset.
`ifndef CAWD_REGS_SVH
`define CAWD_REGS_SVH
// ==========================================================
// Register offsets (byte addresses)
`define CAWD_CTRL_OFS 8'h00
`define CAWD_MODE_OFS 8'h04
`define CAWD_PWMCFG_OFS 8'h08
`define CAWD_CNTL_OFS 8'h0c
`define CAWD_CNTH_OFS 8'h10
`define CAWD_CHMODE_BASE 8'h20
`define CAWD_CHMODE_STEP 8'h04
`define CAWD_CHCMP_BASE 8'h40
`define CAWD_CHCMP_STEP 8'h08
`define CAWD_CHCMP_HI_OFS 8'h04
// ==========================================================
// Field positions
`define CAWD_CTRL_CF 7
`define CAWD_CTRL_CR 6
`define CAWD_MODE_IDLE_CONTROL 7
`define CAWD_MODE_WATCHDOG_ENABLE 6
`define CAWD_MODE_WATCHDOG_LOCK 5
`define CAWD_MODE_ECF 0
`define CAWD_PWM_RELOAD_SELECT 7
`define CAWD_PWM_CYCLE_OVERFLOW_FLAG 5
`define CAWD_WD_CHAN 5
// ==========================================================
// Reset values
`define CAWD_MODE_RST 8'h40
`define CAWD_CYCLE_LENGTH_FIELD_8BIT 2'h0
// ==========================================================
// Timing counts: /12 in system clocks, external /8 in external clock rising edges
`define CAWD_DIV12_LAST 4'hb
`define CAWD_EXT_DIV_LAST 3'h7
`endif

// ===== pkg/cawd_pkg.sv
// Types shared by the counter array block: timebase choices and channel mode fields.
// Assumes nothing beyond a SystemVerilog-2012 tool.
`default_nettype none
package cawd_pkg;
    // Counter timebase selection, in clock_select_field order
    typedef enum logic [2:0] {
        CAWD_SRC_DIV12,
        CAWD_SRC_DIV4,
        CAWD_SRC_T0OVF,
        CAWD_SRC_ECI_FALL,
        CAWD_SRC_SYSTEM_CLOCK,
        CAWD_SRC_EXT_DIV8,
        CAWD_SRC_RSV6,
        CAWD_SRC_RSV7
    } cawd_src_t;

    // Channel mode register layout, bit 7 down to bit 0
    typedef struct packed {
        logic wide_pwm_enable;
        logic compare_enable;
        logic [1:0] unused;
        logic match_flag_enable;
        logic rsv;
        logic pwm_enable;
        logic chan_irq_enable;
    } cawd_mode_t;
endpackage
`default_nettype wire

// ===== rtl/cawd_top.sv
// Six-channel counter array: 8/9/10/11/16-bit PWM and the channel 5 watchdog, APB register access.
// Assumes one 50 MHz clock, synchronous active-low reset, and a reset controller taking WD_RST_O.
// Operation
// - 8-bit PWM: reload byte 0 gives steady high, 0xff gives one count in 256
// - Compare enable cleared forces channel output low in any PWM mode
// - Reload select 1 maps compare addresses to reload register, 0 to compare register
// - N-bit PWM: output goes high when low N counter bits equal compare value
// - N-bit overflow: output low, cycle overflow flag set, reload copied to compare
// - Cycle length field picks N, overflow every 512, 1024 or 2048 counts
// - 9/10/11-bit PWM active with enables set; match flag enable sets event flag
// - Compare low byte write clears compare enable, high byte write sets it
// - 16-bit PWM: high on full match, low on 16-bit overflow which sets overflow flag
// - 16-bit PWM runs on its own enables, independent of cycle length field
// - Watchdog enable makes channel 5 the watchdog: high byte compare, low byte offset
// - After reset watchdog on, timebase /12, counter and offset zero
// - Watchdog on: counter forced running, counter, select, idle frozen, channel 5 mode writes ignored
// - Watchdog on: run bit cannot stop counter and reads as software wrote it
// - Channel 5 high byte write loads counter high byte plus offset
// - Reset when low byte overflows while channel 5 high byte equals counter high byte
// - Writing 1 to channel 5 event flag with watchdog on forces a reset
// - Enable or lock turns watchdog on; lock blocks disabling until reset
// - Clock select: /12, /4, timer 0 overflow, input falling edge, clock, external /8
// - Idle control 1 pauses the whole array while the processor idles
//
// The register addresses and register access over APB were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "cawd_regs.svh"

module cawd_top
    import cawd_pkg::*;
#(
    parameter int NUM_CHAN = 6
) (
    // Clock and reset
    input wire logic CLK_I,
    input wire logic RST_N_I,
    // APB slave
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic PREADY_O,
    output logic PSLVERR_O,
    output logic [31:0] PRDATA_O,
    // System inputs
    input wire logic CPU_IDLE_I,
    input wire logic T0_OVF_I,
    input wire logic ECI_I,
    input wire logic EXT_CLK_I,
    // Outputs
    output logic [NUM_CHAN-1:0] CHAN_OUTPUT_PIN_O,
    output logic WD_RST_O
);
    // ==========================================================
    // Decode helpers
    function automatic logic is_ofs(input logic [7:0] a, input logic [7:0] ofs);
        is_ofs = (a == ofs);
    endfunction

    // Low-N-bit mask for the shared cycle length: 8, 9, 10 or 11 bits
    function automatic logic [15:0] cyc_mask(input logic [1:0] cl);
        cyc_mask = 16'(16'h07ff >> (2'h3 - cl)) | 16'h00ff;
    endfunction

    // ==========================================================
    // State
    logic [7:0] ctrl_reg;
    logic [7:0] mode_reg;
    logic [7:0] pwmcfg_reg;
    logic [15:0] cnt_reg;
    logic [3:0] pre_reg;
    logic [2:0] ext_cnt_reg;
    logic eci_s1_reg, eci_s2_reg, eci_s3_reg;
    logic ext_s1_reg, ext_s2_reg, ext_s3_reg;
    logic [31:0] prdata_reg;
    logic wd_rst_reg;
    logic [15:0] cc_reg [NUM_CHAN];
    logic [15:0] ar_reg [NUM_CHAN];
    cawd_mode_t cm_reg [NUM_CHAN];
    logic [NUM_CHAN-1:0] out_reg;
    logic [NUM_CHAN-1:0] ccf_set;
    logic [NUM_CHAN-1:0] sel_mode, sel_lo, sel_hi;

    // ==========================================================
    // APB decode
    wire logic setup = PSEL_I && !PENABLE_I;
    wire logic wr_en = PSEL_I && PENABLE_I && PWRITE_I;
    wire logic [7:0] wd = PWDATA_I[7:0];
    wire logic sel_ctrl = is_ofs(PADDR_I, `CAWD_CTRL_OFS);
    wire logic sel_md = is_ofs(PADDR_I, `CAWD_MODE_OFS);
    wire logic sel_pwm = is_ofs(PADDR_I, `CAWD_PWMCFG_OFS);
    wire logic sel_cntl = is_ofs(PADDR_I, `CAWD_CNTL_OFS);
    wire logic sel_cnth = is_ofs(PADDR_I, `CAWD_CNTH_OFS);
    wire logic mapped = sel_ctrl | sel_md | sel_pwm | sel_cntl | sel_cnth | (|sel_mode) | (|sel_lo) | (|sel_hi);
    assign PREADY_O = 1'b1; // Zero wait states
    assign PSLVERR_O = PSEL_I && PENABLE_I && !mapped;
    assign PRDATA_O = prdata_reg;

    // ==========================================================
    // Control fields
    wire logic wd_en = mode_reg[`CAWD_MODE_WATCHDOG_ENABLE] | mode_reg[`CAWD_MODE_WATCHDOG_LOCK];
    wire logic reload_select = pwmcfg_reg[`CAWD_PWM_RELOAD_SELECT];
    wire logic [1:0] cycle_length_field = pwmcfg_reg[1:0];
    wire cawd_src_t src = cawd_src_t'(mode_reg[3:1]);
    wire logic [15:0] nmask = cyc_mask(cycle_length_field);

    // Timebase selection; reserved codes give no ticks
    wire logic div12_tick = (pre_reg == `CAWD_DIV12_LAST);
    wire logic div4_tick = (pre_reg[1:0] == 2'h3);
    wire logic eci_fall = eci_s3_reg && !eci_s2_reg;
    wire logic ext_tick = ext_s2_reg && !ext_s3_reg && (ext_cnt_reg == `CAWD_EXT_DIV_LAST);
    logic src_tick;
    always_comb begin
        unique case (src)
            CAWD_SRC_DIV12: src_tick = div12_tick;
            CAWD_SRC_DIV4: src_tick = div4_tick;
            CAWD_SRC_T0OVF: src_tick = T0_OVF_I;
            CAWD_SRC_ECI_FALL: src_tick = eci_fall;
            CAWD_SRC_SYSTEM_CLOCK: src_tick = 1'b1;
            CAWD_SRC_EXT_DIV8: src_tick = ext_tick;
            CAWD_SRC_RSV6: src_tick = 1'b0;
            CAWD_SRC_RSV7: src_tick = 1'b0;
        endcase
    end

    // Run while software or the watchdog asks, unless paused in idle
    wire logic run = (ctrl_reg[`CAWD_CTRL_CR] | wd_en) && !(mode_reg[`CAWD_MODE_IDLE_CONTROL] && CPU_IDLE_I);
    wire logic tick = run && src_tick;
    wire logic [15:0] cnt_next = cnt_reg + 16'h0001;
    wire logic cyc_ovf = tick && ((cnt_next & nmask) == 16'h0000);
    wire logic full_ovf = tick && (cnt_next == 16'h0000);
    wire logic low_ovf = tick && (cnt_reg[7:0] == 8'hff);

    // Watchdog fire: timeout match or forced through the channel 5 flag
    wire logic wd_match = low_ovf && (cc_reg[`CAWD_WD_CHAN][15:8] == cnt_reg[15:8]);
    wire logic wd_force = wr_en && sel_ctrl && wd[`CAWD_WD_CHAN];
    wire logic wd_fire = wd_en && (wd_match || wd_force);
    assign WD_RST_O = wd_rst_reg;
    assign CHAN_OUTPUT_PIN_O = out_reg;

    // ==========================================================
    // Input synchronisers and prescalers
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            eci_s1_reg <= 1'b1;
            eci_s2_reg <= 1'b1;
            eci_s3_reg <= 1'b1;
            ext_s1_reg <= 1'b0;
            ext_s2_reg <= 1'b0;
            ext_s3_reg <= 1'b0;
        end else begin
            eci_s1_reg <= ECI_I;
            eci_s2_reg <= eci_s1_reg;
            eci_s3_reg <= eci_s2_reg;
            ext_s1_reg <= EXT_CLK_I;
            ext_s2_reg <= ext_s1_reg;
            ext_s3_reg <= ext_s2_reg;
        end
    end

    // One prescaler serves /12 and /4 since 12 is a multiple of 4
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            pre_reg <= 4'h0;
            ext_cnt_reg <= 3'h0;
        end else begin
            pre_reg <= div12_tick ? 4'h0 : pre_reg + 4'h1;
            if (ext_s2_reg && !ext_s3_reg) begin
                ext_cnt_reg <= ext_cnt_reg + 3'h1;
            end
        end
    end

    // ==========================================================
    // Counter; bus writes blocked while the watchdog runs
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            cnt_reg <= 16'h0000;
        end else if (wr_en && sel_cntl && !wd_en) begin
            cnt_reg[7:0] <= wd;
        end else if (wr_en && sel_cnth && !wd_en) begin
            cnt_reg[15:8] <= wd;
        end else if (tick) begin
            cnt_reg <= cnt_next;
        end
    end

    // ==========================================================
    // Control, mode and PWM config; hardware set wins over software clear
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            ctrl_reg <= 8'h00;
            mode_reg <= `CAWD_MODE_RST;
            pwmcfg_reg <= 8'h00;
        end else begin
            if (wr_en && sel_ctrl) begin
                ctrl_reg <= wd | {full_ovf, 1'b0, ccf_set};
            end else begin
                ctrl_reg <= ctrl_reg | {full_ovf, 1'b0, ccf_set};
            end
            if (wr_en && sel_md) begin
                // Lock is sticky until reset; select and idle frozen while enabled
                mode_reg[`CAWD_MODE_WATCHDOG_LOCK] <= mode_reg[`CAWD_MODE_WATCHDOG_LOCK] | wd[`CAWD_MODE_WATCHDOG_LOCK];
                mode_reg[`CAWD_MODE_WATCHDOG_ENABLE] <= wd[`CAWD_MODE_WATCHDOG_ENABLE] | mode_reg[`CAWD_MODE_WATCHDOG_LOCK];
                mode_reg[`CAWD_MODE_ECF] <= wd[`CAWD_MODE_ECF];
                if (!wd_en) begin
                    mode_reg[`CAWD_MODE_IDLE_CONTROL] <= wd[`CAWD_MODE_IDLE_CONTROL];
                    mode_reg[3:1] <= wd[3:1];
                end
            end
            if (wr_en && sel_pwm) begin
                pwmcfg_reg <= {wd[7:6], wd[5] | cyc_ovf, 3'h0, wd[1:0]};
            end else begin
                pwmcfg_reg[`CAWD_PWM_CYCLE_OVERFLOW_FLAG] <= pwmcfg_reg[`CAWD_PWM_CYCLE_OVERFLOW_FLAG] | cyc_ovf;
            end
        end
    end

    // Watchdog reset request, one registered clock
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            wd_rst_reg <= 1'b0;
        end else begin
            wd_rst_reg <= wd_fire;
        end
    end

    // ==========================================================
    // Channels
    genvar n;
    generate
        for (n = 0; n < NUM_CHAN; n++) begin : g_chan
            wire logic [7:0] mofs = 8'(`CAWD_CHMODE_BASE + n * `CAWD_CHMODE_STEP);
            wire logic [7:0] cofs = 8'(`CAWD_CHCMP_BASE + n * `CAWD_CHCMP_STEP);
            assign sel_mode[n] = is_ofs(PADDR_I, mofs);
            assign sel_lo[n] = is_ofs(PADDR_I, cofs);
            assign sel_hi[n] = is_ofs(PADDR_I, 8'(cofs + `CAWD_CHCMP_HI_OFS));
            wire logic is_wd = (n == `CAWD_WD_CHAN) && wd_en;
            // Watchdog channel is held as a software timer
            wire logic ecom = is_wd | cm_reg[n].compare_enable;
            wire logic mat = is_wd | cm_reg[n].match_flag_enable;
            wire logic pwm_act = !is_wd && cm_reg[n].compare_enable && cm_reg[n].pwm_enable;
            wire logic wide = cm_reg[n].wide_pwm_enable;
            wire logic [15:0] m = wide ? 16'hffff : nmask;
            wire logic ovf = wide ? full_ovf : cyc_ovf;
            wire logic match = pwm_act ? ((cnt_next & m) == (cc_reg[n] & m)) : (cnt_next == cc_reg[n]);
            // Reload value: 8-bit copies high byte into low, 9-11 bit takes auto-reload, 16-bit keeps
            wire logic is8 = (cycle_length_field == `CAWD_CYCLE_LENGTH_FIELD_8BIT);
            wire logic [15:0] rl = wide ? cc_reg[n] : (is8 ? {cc_reg[n][15:8], cc_reg[n][15:8]} : ar_reg[n]);
            wire logic wlo = wr_en && sel_lo[n];
            wire logic whi = wr_en && sel_hi[n];
            assign ccf_set[n] = tick && ecom && mat && match && !(pwm_act && ovf);

            // Compare and auto-reload registers
            always_ff @(posedge CLK_I) begin
                if (!RST_N_I) begin
                    cc_reg[n] <= 16'h0000;
                    ar_reg[n] <= 16'h0000;
                end else if (wlo) begin
                    if (reload_select) begin
                        ar_reg[n][7:0] <= wd;
                    end else begin
                        cc_reg[n][7:0] <= wd;
                    end
                end else if (whi) begin
                    if (is_wd) begin
                        cc_reg[n][15:8] <= cnt_reg[15:8] + cc_reg[n][7:0];
                    end else if (reload_select) begin
                        ar_reg[n][15:8] <= wd;
                    end else begin
                        cc_reg[n][15:8] <= wd;
                    end
                end else if (pwm_act && ovf && !wide) begin
                    cc_reg[n] <= rl;
                end
            end

            // Mode register; writes to the watchdog channel mode are ignored, compare writes still move its enable
            always_ff @(posedge CLK_I) begin
                if (!RST_N_I) begin
                    cm_reg[n] <= '0;
                end else if (wr_en && sel_mode[n] && !is_wd) begin
                    cm_reg[n] <= cawd_mode_t'(wd);
                end else if (wlo) begin
                    cm_reg[n].compare_enable <= 1'b0;
                end else if (whi) begin
                    cm_reg[n].compare_enable <= 1'b1;
                end
            end

            // PWM output: high on match, low on overflow unless reload of zero keeps it high
            always_ff @(posedge CLK_I) begin
                if (!RST_N_I || !pwm_act) begin
                    out_reg[n] <= 1'b0;
                end else if (ovf) begin
                    out_reg[n] <= ((rl & m) == 16'h0000);
                end else if (tick && match) begin
                    out_reg[n] <= 1'b1;
                end
            end
        end
    endgenerate

    // ==========================================================
    // Read data, captured in the setup phase
    logic [7:0] rd_byte;
    always_comb begin
        rd_byte = 8'h00;
        if (sel_ctrl) rd_byte = ctrl_reg;
        if (sel_md) rd_byte = {mode_reg[7:5], 1'b0, mode_reg[3:0]};
        if (sel_pwm) rd_byte = pwmcfg_reg;
        if (sel_cntl) rd_byte = cnt_reg[7:0];
        if (sel_cnth) rd_byte = cnt_reg[15:8];
        for (int i = 0; i < NUM_CHAN; i++) begin
            if (sel_mode[i]) rd_byte = cm_reg[i];
            if (sel_lo[i]) rd_byte = reload_select ? ar_reg[i][7:0] : cc_reg[i][7:0];
            if (sel_hi[i]) rd_byte = reload_select ? ar_reg[i][15:8] : cc_reg[i][15:8];
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            prdata_reg <= 32'h0000_0000;
        end else if (setup && !PWRITE_I) begin
            prdata_reg <= {24'h00_0000, rd_byte};
        end
    end
endmodule
`default_nettype wire

// ===== verification/cawd_assertions.sv
// Checker for the counter array block: bus timing and watchdog reset behaviour.
// Assumes it is bound to cawd_top and sees only that module's ports.
`timescale 1ns/1ns
`default_nettype none
module cawd_assertions
    import cawd_pkg::*;
#(
    parameter int NUM_CHAN = 6
) (
    // Clock and reset
    input wire logic CLK_I,
    input wire logic RST_N_I,
    // APB slave
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    input wire logic PREADY_O,
    input wire logic PSLVERR_O,
    input wire logic [31:0] PRDATA_O,
    // Outputs
    input wire logic [NUM_CHAN-1:0] CHAN_OUTPUT_PIN_O,
    input wire logic WD_RST_O
);
    // ====================
    // Shadow of watchdog state
    wire wr_acc = PSEL_I && PENABLE_I && PWRITE_I && PREADY_O;
    wire wr_mode = wr_acc && (PADDR_I == 8'h04);
    logic lock_reg;
    logic wd_on_reg;
    logic wr_seen_reg;
    logic pulse_seen_reg;
    logic [11:0] cnt_reg;
    // Lock is sticky, so the shadow only drops enable when unlocked
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            lock_reg <= 1'b0;
            wd_on_reg <= 1'b1;
            wr_seen_reg <= 1'b0;
            pulse_seen_reg <= 1'b0;
            cnt_reg <= 12'h000;
        end else begin
            if (wr_mode) begin
                lock_reg <= lock_reg | PWDATA_I[5];
                wd_on_reg <= lock_reg | PWDATA_I[6] | PWDATA_I[5];
            end
            if (wr_acc) wr_seen_reg <= 1'b1;
            if (WD_RST_O) pulse_seen_reg <= 1'b1;
            if (cnt_reg != 12'hfff) cnt_reg <= cnt_reg + 12'h001;
        end
    end
    // ====================
    // Properties
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_N_I);
    chk_wdrst_pulse: assert property (WD_RST_O |=> !WD_RST_O)
        else $error("watchdog reset wider than one clock");
    chk_chan5_event_flag_force: assert property ((wr_acc && PADDR_I == 8'h00 && PWDATA_I[5] && wd_on_reg) |-> ##[1:2] WD_RST_O)
        else $error("flag write gave no watchdog reset");
    chk_wd_silent: assert property ((!wd_on_reg && !$past(wd_on_reg)) |-> !WD_RST_O)
        else $error("reset request while watchdog off");
    chk_wd_early: assert property ((!wr_seen_reg && cnt_reg < 12'd3000) |-> !WD_RST_O)
        else $error("watchdog fired too early");
    chk_wd_timeout: assert property ((!wr_seen_reg && cnt_reg == 12'd3100) |-> pulse_seen_reg)
        else $error("watchdog did not fire");
    chk_err_phase: assert property (PSLVERR_O |-> (PSEL_I && PENABLE_I))
        else $error("error outside access phase");
    chk_rd_upper: assert property (PRDATA_O[31:8] == 24'h000000)
        else $error("upper read bits not zero");
    chk_out_idle: assert property ($rose(RST_N_I) |-> (CHAN_OUTPUT_PIN_O == '0 && !WD_RST_O))
        else $error("outputs active after reset");
endmodule
bind cawd_top cawd_assertions #(.NUM_CHAN(NUM_CHAN)) u_chk (.CLK_I(CLK_I), .RST_N_I(RST_N_I),
    .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I),
    .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .PRDATA_O(PRDATA_O),
    .CHAN_OUTPUT_PIN_O(CHAN_OUTPUT_PIN_O), .WD_RST_O(WD_RST_O));
`default_nettype wire

// ===== verification/cawd_cpu_model.sv
// Processor core model: issues register transfers as an APB master.
// Assumes one shared clock; the slave may stretch the access phase.
`timescale 1ns/1ns
`default_nettype none
module cawd_cpu_model
    import cawd_pkg::*;
(
    // Clock
    input wire logic clk_i,
    // APB master side
    output logic psel_o,
    output logic penable_o,
    output logic pwrite_o,
    output logic [7:0] paddr_o,
    output logic [31:0] pwdata_o,
    input wire logic pready_i,
    input wire logic pslverr_i,
    input wire logic [31:0] prdata_i
);
    // ====================
    // Idle bus at time zero
    initial begin
        psel_o = 1'b0;
        penable_o = 1'b0;
        pwrite_o = 1'b0;
        paddr_o = 8'h00;
        pwdata_o = 32'h0;
    end
    // One transfer; request held until ready is seen high
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                        output logic [7:0] q, output logic e);
        @(posedge clk_i);
        psel_o <= 1'b1;
        penable_o <= 1'b0;
        pwrite_o <= w;
        paddr_o <= a;
        pwdata_o <= {24'h0, d};
        @(posedge clk_i);
        penable_o <= 1'b1;
        do @(posedge clk_i); while (pready_i !== 1'b1);
        q = prdata_i[7:0];
        e = pslverr_i;
        psel_o <= 1'b0;
        penable_o <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ===== verification/cawd_top_tb.sv
// Testbench for the counter array: watchdog, register access and PWM duty.
// Assumes the core model and the bound checker; the external count and clock pins stay low.
`timescale 1ns/1ns
`default_nettype none
module cawd_top_tb
    import cawd_pkg::*;
;
    logic clk, rst_n, psel, penable, pwrite, pready, pslverr, wdr;
    logic tie_lo = 1'b0, idle = 1'b0, t0 = 1'b0;
    logic [7:0] paddr, q;
    logic [31:0] pwdata, prdata;
    logic [5:0] pins;
    logic e;
    int n, len, failures = 0, num_checks = 0;
    logic [7:0] hv[2] = '{8'h00, 8'hff};
    cawd_top dut (.CLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
        .PADDR_I(paddr), .PWDATA_I(pwdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .PRDATA_O(prdata),
        .CPU_IDLE_I(idle), .T0_OVF_I(t0), .ECI_I(tie_lo), .EXT_CLK_I(tie_lo),
        .CHAN_OUTPUT_PIN_O(pins), .WD_RST_O(wdr));
    cawd_cpu_model cpu (.clk_i(clk), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
        .paddr_o(paddr), .pwdata_o(pwdata), .pready_i(pready), .pslverr_i(pslverr), .prdata_i(prdata));
    // ====================
    // Clock, 20 ns period
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] v;
        logic er;
        cpu.xfer(1'b1, a, d, v, er);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] x);
        logic [7:0] v;
        logic er;
        cpu.xfer(1'b0, a, 8'h00, v, er);
        check({24'h0, v}, {24'h0, x});
    endtask
    task automatic do_reset;
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
    endtask
    // Bounded wait for the reset request; sampled on the falling edge, where outputs have settled
    task automatic wait_wd(input int lim);
        n = 0;
        while (wdr !== 1'b1 && n < lim) begin
            @(negedge clk);
            n++;
        end
    endtask
    // Exactly one period is sampled, so the count is phase independent
    task automatic count_high(input int l);
        n = 0;
        repeat (l) begin
            @(negedge clk);
            if (pins[0] === 1'b1) n++;
        end
    endtask
    task automatic end_sim;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // ====================
    // Watchdog for hangs, well beyond the expected run
    initial begin
        repeat (40000) @(posedge clk);
        failures++;
        end_sim;
    end
    // ====================
    // Test sequence
    initial begin
        rst_n = 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        rdchk(8'h04, 8'h40);
        rdchk(8'h00, 8'h00);
        wait_wd(3500);
        check(32'(n >= 3050 && n <= 3085), 32'h1);
        repeat (60) @(posedge clk);
        do_reset;
        wr(8'h04, 8'h48);
        rdchk(8'h04, 8'h40);
        wr(8'h68, 8'h01);
        wr(8'h6c, 8'haa);
        rdchk(8'h6c, 8'h01);
        wr(8'h00, 8'h20);
        wait_wd(4);
        check({31'h0, wdr}, 32'h1);
        do_reset;
        wr(8'h04, 8'h20);
        wr(8'h04, 8'h00);
        wr(8'h00, 8'h20);
        wait_wd(4);
        check({31'h0, wdr}, 32'h1);
        do_reset;
        wr(8'h04, 8'h00);
        wr(8'h04, 8'h08);
        rdchk(8'h04, 8'h08);
        wr(8'h00, 8'h40);
        // Idle pause freezes the counter, then five timer 0 pulses give five counts
        wr(8'h04, 8'h88);
        idle <= 1'b1;
        cpu.xfer(1'b0, 8'h0c, 8'h00, q, e);
        rdchk(8'h0c, q);
        idle <= 1'b0;
        wr(8'h04, 8'h04);
        cpu.xfer(1'b0, 8'h0c, 8'h00, q, e);
        repeat (5) begin
            t0 <= 1'b1;
            @(posedge clk);
            t0 <= 1'b0;
            @(posedge clk);
        end
        rdchk(8'h0c, q + 8'h05);
        wr(8'h04, 8'h08);
        cpu.xfer(1'b0, 8'hfc, 8'h00, q, e);
        check({31'h0, e}, 32'h1);
        wr(8'h08, 8'h00);
        wr(8'h20, 8'h4a);
        wr(8'h40, 8'h00);
        rdchk(8'h20, 8'h0a);
        foreach (hv[i]) begin
            wr(8'h40, 8'h00);
            wr(8'h44, hv[i]);
            rdchk(8'h20, 8'h4a);
            repeat (600) @(posedge clk);
            count_high(256);
            check(32'(n), 32'(256 - int'(hv[i])));
        end
        wr(8'h20, 8'h0a);
        repeat (300) @(posedge clk);
        count_high(256);
        check(32'(n), 32'h0);
        for (int k = 1; k < 4; k++) begin
            len = 256 << k;
            wr(8'h08, 8'h80 | 8'(k));
            wr(8'h40, 8'h00);
            wr(8'h44, 8'h01);
            wr(8'h08, 8'(k));
            wr(8'h00, 8'h40);
            repeat (2 * len) @(posedge clk);
            count_high(len);
            check(32'(n), 32'(len - 256));
            rdchk(8'h44, 8'h01);
            cpu.xfer(1'b0, 8'h08, 8'h00, q, e);
            check({31'h0, q[5]}, 32'h1);
            cpu.xfer(1'b0, 8'h00, 8'h00, q, e);
            check({31'h0, q[0]}, 32'h1);
        end
        // 16-bit PWM on channel 1, counter preset close to its top so the cycle stays short
        wr(8'h24, 8'hcb);
        wr(8'h48, 8'h00);
        wr(8'h4c, 8'hff);
        wr(8'h0c, 8'h00);
        wr(8'h10, 8'hfe);
        repeat (300) @(negedge clk);
        check({31'h0, pins[1]}, 32'h1);
        repeat (300) @(negedge clk);
        check({31'h0, pins[1]}, 32'h0);
        cpu.xfer(1'b0, 8'h00, 8'h00, q, e);
        check({30'h0, q[7], q[1]}, 32'h3);
        end_sim;
    end
endmodule
`default_nettype wire
